// *** hdl/isr_defs.svh ***
// status reporting constants: bit positions, reset values, reply codes
// assumes inclusion by bare name from the design files
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH

`define ISR_STB_ERROR_PENDING_FLAG 2
`define ISR_STB_REPLY_WAITING_FLAG 4
`define ISR_STB_EVENT_SUMMARY_FLAG 5
`define ISR_STB_RQS 6
`define ISR_ESR_OPERATION_DONE_EVENT 0
`define ISR_SRE_RST 8'h00
`define ISR_ESE_RST 8'h00
`define ISR_ESR_RST 8'h00
`define ISR_STB_RST 8'h00
`define ISR_SRE_MASK 8'hbf
`define ISR_DONE_REPLY 8'h31
`define ISR_EMPTY_REPLY 8'h00
`define ISR_EXT_EVT_MASK 8'hfe

`endif

// *** hdl/isr_pkg.sv ***
// types of the status reporting block: command codes and port bundles
// assumes the controller side decodes its text commands into these codes
package isr_pkg;

   typedef enum logic [3:0] {
      ISR_CMD_NONE = 4'b0000,
      ISR_CMD_STB_QUERY = 4'b0001,
      ISR_CMD_SERIAL_POLL = 4'b0010,
      ISR_CMD_ERR_QUERY = 4'b0011,
      ISR_CMD_SRE_WRITE = 4'b0100,
      ISR_CMD_SRE_QUERY = 4'b0101,
      ISR_CMD_ESE_WRITE = 4'b0110,
      ISR_CMD_ESE_QUERY = 4'b0111,
      ISR_CMD_ESR_QUERY = 4'b1000,
      ISR_CMD_CLS = 4'b1001,
      ISR_CMD_OP_DONE = 4'b1010,
      ISR_CMD_OP_DONE_QUERY = 4'b1011,
      ISR_CMD_OUT_READ = 4'b1100
   } isr_cmd_code_t;

   typedef struct packed {
      logic valid;
      isr_cmd_code_t code;
      logic [7:0] data;
   } isr_cmd_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } isr_rsp_t;

endpackage

// *** hdl/isr_fifo.sv ***
// first-in first-out queue in flip-flops, used for error and output queues
// assumes one clock; flush and push in one cycle keep the pushed entry
`timescale 1ns/10ps
module isr_fifo #(
   parameter int W = 8,
   parameter int D = 4,
   localparam int AW = (D > 1) ? $clog2(D) : 1,
   localparam int CW = $clog2(D + 1)
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic flush,
   input wire logic push,
   input wire logic [W-1:0] push_data,
   input wire logic pop,
   output logic [W-1:0] head,
   output logic [CW-1:0] count,
   output logic full,
   output logic empty
);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic wr_en;
   logic rd_en;
   logic [AW-1:0] wr_idx;

   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   assign empty = (cnt_q == '0);
   assign full = (cnt_q == CW'(D));
   // a pop frees the slot a full-queue push needs
   assign wr_en = push && (flush || !full || pop);
   assign rd_en = pop && !empty && !flush;
   assign wr_idx = flush ? '0 : wr_ptr_q;
   assign head = mem[rd_ptr_q];
   assign count = cnt_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         rd_ptr_q <= '0;
         wr_ptr_q <= push ? ptr_inc('0) : '0;
         cnt_q <= push ? CW'(1) : '0;
      end else begin
         if (wr_en)
            wr_ptr_q <= ptr_inc(wr_ptr_q);
         if (rd_en)
            rd_ptr_q <= ptr_inc(rd_ptr_q);
         if (wr_en && !rd_en)
            cnt_q <= CW'(cnt_q + 1'b1);
         else if (rd_en && !wr_en)
            cnt_q <= CW'(cnt_q - 1'b1);
      end
   end

   for (genvar i = 0; i < D; i++) begin : g_entry
      always_ff @(posedge clk) begin
         if (wr_en && wr_idx == AW'(i))
            mem[i] <= push_data;
      end
   end

endmodule

// *** hdl/isr_status_top.sv ***
// status summary byte, standard event register, enables and service request
// assumes the controller interface decodes commands and delivers one per cycle
`timescale 1ns/10ps
`include "isr_defs.svh"
module isr_status_top #(
   parameter int ERR_DEPTH = 10,
   parameter int OUT_DEPTH = 4
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire isr_pkg::isr_cmd_t CMD,
   input wire logic OP_BUSY,
   input wire logic ERR_PUSH,
   input wire logic [7:0] ERR_CODE,
   input wire logic [7:0] STD_EVENT,
   output isr_pkg::isr_rsp_t RSP,
   output logic [7:0] STATUS_BYTE,
   output logic SRQ
);

   localparam int ECW = $clog2(ERR_DEPTH + 1);
   localparam int OCW = $clog2(OUT_DEPTH + 1);

   logic is_stb;
   logic is_poll;
   logic is_err_rd;
   logic is_sre_wr;
   logic is_sre_rd;
   logic is_ese_wr;
   logic is_ese_rd;
   logic is_esr_rd;
   logic is_cls;
   logic is_done_set;
   logic is_opcq;
   logic is_out_rd;

   logic [7:0] sre_q;
   logic [7:0] ese_q;
   logic [7:0] esr_q;
   logic [7:0] esr_d;
   logic [7:0] stb_d;
   logic [7:0] stb_q;
   logic srq_d;
   logic srq_q;
   logic done_pend_q;
   logic opcq_pend_q;
   logic done_fire;
   logic opcq_fire;
   isr_pkg::isr_rsp_t rsp_q;

   logic [7:0] err_head;
   logic [ECW-1:0] err_cnt;
   logic err_full;
   logic err_empty;
   logic err_pop;
   logic [7:0] out_head;
   logic [OCW-1:0] out_cnt;
   logic out_full;
   logic out_empty;
   logic out_pop;

   always_comb begin
      is_stb = 1'b0;
      is_poll = 1'b0;
      is_err_rd = 1'b0;
      is_sre_wr = 1'b0;
      is_sre_rd = 1'b0;
      is_ese_wr = 1'b0;
      is_ese_rd = 1'b0;
      is_esr_rd = 1'b0;
      is_cls = 1'b0;
      is_done_set = 1'b0;
      is_opcq = 1'b0;
      is_out_rd = 1'b0;
      if (CMD.valid) begin
         case (CMD.code)
            isr_pkg::ISR_CMD_STB_QUERY: is_stb = 1'b1;
            isr_pkg::ISR_CMD_SERIAL_POLL: is_poll = 1'b1;
            isr_pkg::ISR_CMD_ERR_QUERY: is_err_rd = 1'b1;
            isr_pkg::ISR_CMD_SRE_WRITE: is_sre_wr = 1'b1;
            isr_pkg::ISR_CMD_SRE_QUERY: is_sre_rd = 1'b1;
            isr_pkg::ISR_CMD_ESE_WRITE: is_ese_wr = 1'b1;
            isr_pkg::ISR_CMD_ESE_QUERY: is_ese_rd = 1'b1;
            isr_pkg::ISR_CMD_ESR_QUERY: is_esr_rd = 1'b1;
            isr_pkg::ISR_CMD_CLS: is_cls = 1'b1;
            isr_pkg::ISR_CMD_OP_DONE: is_done_set = 1'b1;
            isr_pkg::ISR_CMD_OP_DONE_QUERY: is_opcq = 1'b1;
            isr_pkg::ISR_CMD_OUT_READ: is_out_rd = 1'b1;
            default: ;
         endcase
      end
   end

   // error queue, oldest first; a full queue drops the newest error
   assign err_pop = is_err_rd && !err_empty;

   isr_fifo #(.W(8), .D(ERR_DEPTH)) u_err_queue (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .flush(is_cls),
      .push(ERR_PUSH),
      .push_data(ERR_CODE),
      .pop(err_pop),
      .head(err_head),
      .count(err_cnt),
      .full(err_full),
      .empty(err_empty)
   );

   // output queue carries operation-complete query replies
   assign out_pop = is_out_rd && !out_empty;
   assign opcq_fire = opcq_pend_q && !OP_BUSY && !out_full;

   isr_fifo #(.W(8), .D(OUT_DEPTH)) u_out_queue (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .flush(1'b0),
      .push(opcq_fire),
      .push_data(`ISR_DONE_REPLY),
      .pop(out_pop),
      .head(out_head),
      .count(out_cnt),
      .full(out_full),
      .empty(out_empty)
   );

   // enables; the request bit position is always masked off and cannot be enabled
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B)
         sre_q <= `ISR_SRE_RST;
      else if (is_sre_wr)
         sre_q <= CMD.data & `ISR_SRE_MASK;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B)
         ese_q <= `ISR_ESE_RST;
      else if (is_ese_wr)
         ese_q <= CMD.data;
   end

   // done waits for the running operation; clear-status drops the wait
   assign done_fire = done_pend_q && !OP_BUSY;

   // a request taken in the firing cycle stays pending, else it would be lost
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B)
         done_pend_q <= 1'b0;
      else if (is_cls)
         done_pend_q <= 1'b0;
      else if (is_done_set)
         done_pend_q <= 1'b1;
      else if (done_fire)
         done_pend_q <= 1'b0;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B)
         opcq_pend_q <= 1'b0;
      else if (is_cls)
         opcq_pend_q <= 1'b0;
      else if (is_opcq)
         opcq_pend_q <= 1'b1;
      else if (opcq_fire)
         opcq_pend_q <= 1'b0;
   end

   // new events win over a clear in the same cycle
   always_comb begin
      esr_d = (is_esr_rd || is_cls) ? `ISR_ESR_RST : esr_q;
      esr_d = esr_d | (STD_EVENT & `ISR_EXT_EVT_MASK);
      esr_d[`ISR_ESR_OPERATION_DONE_EVENT] = esr_d[`ISR_ESR_OPERATION_DONE_EVENT] | done_fire;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B)
         esr_q <= `ISR_ESR_RST;
      else
         esr_q <= esr_d;
   end

   // summary byte from present state; request bit summarises the rest
   always_comb begin
      stb_d = 8'h00;
      stb_d[`ISR_STB_ERROR_PENDING_FLAG] = !err_empty;
      stb_d[`ISR_STB_REPLY_WAITING_FLAG] = !out_empty;
      stb_d[`ISR_STB_EVENT_SUMMARY_FLAG] = |(esr_q & ese_q);
      srq_d = |(stb_d & sre_q & `ISR_SRE_MASK);
      stb_d[`ISR_STB_RQS] = srq_d;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         stb_q <= `ISR_STB_RST;
         srq_q <= 1'b0;
      end else begin
         stb_q <= stb_d;
         srq_q <= srq_d;
      end
   end

   // one reply per query except the operation-complete query, the cycle after it is taken
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= is_stb || is_poll || is_err_rd || is_sre_rd || is_ese_rd || is_esr_rd || is_out_rd;
         if (is_stb || is_poll)
            rsp_q.data <= stb_d;
         else if (is_err_rd)
            rsp_q.data <= err_empty ? `ISR_EMPTY_REPLY : err_head;
         else if (is_sre_rd)
            rsp_q.data <= sre_q;
         else if (is_ese_rd)
            rsp_q.data <= ese_q;
         else if (is_esr_rd)
            rsp_q.data <= esr_q;
         else if (is_out_rd)
            rsp_q.data <= out_empty ? `ISR_EMPTY_REPLY : out_head;
         else
            rsp_q.data <= 8'h00;
      end
   end

   assign RSP = rsp_q;
   assign STATUS_BYTE = stb_q;
   assign SRQ = srq_q;

   a_pend_on_error: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      ERR_PUSH && !err_full |-> ##2 STATUS_BYTE[`ISR_STB_ERROR_PENDING_FLAG])
      else $error("error-pending flag missing after error");

   a_stb_reply_value: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      (is_stb || is_poll) |=> RSP.valid && RSP.data == $past(stb_d))
      else $error("status byte reply wrong");

   a_err_read_clears: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      is_err_rd && err_cnt == ECW'(1) && !ERR_PUSH |-> ##2 !STATUS_BYTE[`ISR_STB_ERROR_PENDING_FLAG])
      else $error("error-pending flag not cleared by last read");

   a_srq_on_pend: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      $past(sre_q) == 8'h04 |-> SRQ == STATUS_BYTE[`ISR_STB_ERROR_PENDING_FLAG])
      else $error("service request does not follow error-pending");

   a_opcq_hold_busy: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      opcq_pend_q && OP_BUSY && !is_cls |=> opcq_pend_q && out_cnt == $past(out_cnt) - OCW'(out_pop))
      else $error("done reply queued while busy");

   a_opcq_reply_push: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      opcq_pend_q && !OP_BUSY && !out_full && !out_pop |=> out_cnt == OCW'($past(out_cnt) + 1'b1))
      else $error("done reply not queued");

   a_query_cmd_pends: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      is_opcq |=> opcq_pend_q)
      else $error("done reply request lost");

   a_done_cmd_pends: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      is_done_set |=> done_pend_q)
      else $error("done request lost");

   a_wait_tracks_queue: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      out_pop && out_cnt == OCW'(1) && !opcq_fire |-> ##2 !STATUS_BYTE[`ISR_STB_REPLY_WAITING_FLAG])
      else $error("reply-waiting flag not cleared");

   a_summary_from_done: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      done_fire && ese_q[`ISR_ESR_OPERATION_DONE_EVENT] && !is_ese_wr |-> ##2 STATUS_BYTE[`ISR_STB_EVENT_SUMMARY_FLAG])
      else $error("event-summary flag missing after done");

   a_summary_level: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      |(esr_q & ese_q) |=> STATUS_BYTE[`ISR_STB_EVENT_SUMMARY_FLAG])
      else $error("event-summary flag low with enabled event");

   a_esr_read_clear: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      is_esr_rd && (STD_EVENT & `ISR_EXT_EVT_MASK) == 8'h00 && !done_fire
      |=> esr_q == 8'h00 && RSP.data == $past(esr_q))
      else $error("event register not returned and cleared");

   a_cls_clears_all: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      is_cls && !ERR_PUSH && (STD_EVENT & `ISR_EXT_EVT_MASK) == 8'h00 && !done_fire
      |=> err_cnt == '0 && esr_q == 8'h00 && !done_pend_q && !opcq_pend_q)
      else $error("clear-status left state behind");

   a_srq_on_summary: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      $past(sre_q) == 8'h20 |-> SRQ == STATUS_BYTE[`ISR_STB_EVENT_SUMMARY_FLAG])
      else $error("service request does not follow event summary");

   a_srq_and_mask: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      ##1 SRQ == |(STATUS_BYTE & $past(sre_q) & `ISR_SRE_MASK) && SRQ == STATUS_BYTE[`ISR_STB_RQS])
      else $error("service request not equal to masked byte");

   a_err_oldest_first: assert property (@(posedge REF_CLK) disable iff (!RST_B)
      is_err_rd && err_cnt > ECW'(1) |=> RSP.data == $past(err_head) ##1 STATUS_BYTE[`ISR_STB_ERROR_PENDING_FLAG])
      else $error("error order or flag wrong");

endmodule

// *** sim/isr_ctrl_model.sv ***
// remote controller model: sends decoded commands to the status block
// assumes the bench calls send and drives the busy level itself
`timescale 1ns/10ps
module isr_ctrl_model (
   input wire logic clk,
   input wire logic op_busy,
   output isr_pkg::isr_cmd_t cmd
);
   initial begin
      cmd = '0;
   end
   task automatic send(input isr_pkg::isr_cmd_code_t code, input logic [7:0] data);
      // done requests and polls may ride right behind a running step; a stuck busy ends in the bench timeout
      while (op_busy === 1'b1 && !(code inside {isr_pkg::ISR_CMD_OP_DONE, isr_pkg::ISR_CMD_OP_DONE_QUERY,
            isr_pkg::ISR_CMD_SERIAL_POLL})) begin
         @(posedge clk);
      end
      @(posedge clk);
      cmd <= '{1'b1, code, data};
      @(posedge clk);
      // released lines carry inverted data so a stale byte is never mistaken
      cmd <= '{1'b0, isr_pkg::ISR_CMD_NONE, ~data};
   endtask
endmodule

// *** sim/instrument_status_reporting_tb.sv ***
// self-checking bench for the status reporting block
// assumes the controller model issues commands; bench drives busy, errors, events
`timescale 1ns/10ps
module instrument_status_reporting_tb;
   logic ref_clk;
   logic rst_b;
   logic op_busy;
   logic err_push;
   logic [7:0] err_code;
   logic [7:0] std_event;
   isr_pkg::isr_cmd_t cmd;
   isr_pkg::isr_rsp_t rsp;
   logic [7:0] status_byte;
   logic srq;
   int mismatches;
   int samples_checked;
   int cycles;

   isr_status_top isr_status_top_inst (
      .REF_CLK(ref_clk), .RST_B(rst_b), .CMD(cmd), .OP_BUSY(op_busy), .ERR_PUSH(err_push),
      .ERR_CODE(err_code), .STD_EVENT(std_event), .RSP(rsp), .STATUS_BYTE(status_byte), .SRQ(srq)
   );
   isr_ctrl_model isr_ctrl_model_inst (.clk(ref_clk), .op_busy(op_busy), .cmd(cmd));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input isr_pkg::isr_cmd_code_t c, input logic [7:0] v);
      isr_ctrl_model_inst.send(c, v);
   endtask
   // reply stands from the taking edge on, so sample it just past that edge
   task automatic ask(input isr_pkg::isr_cmd_code_t c, input logic [7:0] exp);
      wr(c, 8'h00);
      #1;
      check({7'h00, rsp.valid}, 8'h01);
      check(rsp.data, exp);
   endtask
   task automatic stop_test();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic t_reset();
      check(status_byte, 8'h00);
      check({7'h00, srq}, 8'h00);
      ask(isr_pkg::ISR_CMD_SRE_QUERY, 8'h00);
      ask(isr_pkg::ISR_CMD_ESE_QUERY, 8'h00);
      ask(isr_pkg::ISR_CMD_ESR_QUERY, 8'h00);
      ask(isr_pkg::ISR_CMD_OUT_READ, 8'h00);
   endtask
   task automatic t_error();
      wr(isr_pkg::ISR_CMD_SRE_WRITE, 8'hff);
      ask(isr_pkg::ISR_CMD_SRE_QUERY, 8'hbf);
      wr(isr_pkg::ISR_CMD_SRE_WRITE, 8'h04);
      @(posedge ref_clk);
      err_push <= 1'b1;
      err_code <= 8'h11;
      @(posedge ref_clk);
      err_code <= 8'h22;
      @(posedge ref_clk);
      err_push <= 1'b0;
      err_code <= 8'hdd;
      tick(2);
      check({7'h00, srq}, 8'h01);
      ask(isr_pkg::ISR_CMD_STB_QUERY, 8'h44);
      ask(isr_pkg::ISR_CMD_SERIAL_POLL, 8'h44);
      ask(isr_pkg::ISR_CMD_ERR_QUERY, 8'h11);
      tick(1);
      check(status_byte & 8'h04, 8'h04);
      ask(isr_pkg::ISR_CMD_ERR_QUERY, 8'h22);
      tick(1);
      check(status_byte & 8'h04, 8'h00);
      check({7'h00, srq}, 8'h00);
      ask(isr_pkg::ISR_CMD_ERR_QUERY, 8'h00);
   endtask
   task automatic t_done();
      wr(isr_pkg::ISR_CMD_ESE_WRITE, 8'h01);
      wr(isr_pkg::ISR_CMD_SRE_WRITE, 8'h20);
      ask(isr_pkg::ISR_CMD_ESE_QUERY, 8'h01);
      @(posedge ref_clk);
      op_busy <= 1'b1;
      wr(isr_pkg::ISR_CMD_OP_DONE, 8'h00);
      tick(4);
      check(status_byte, 8'h00);
      @(posedge ref_clk);
      op_busy <= 1'b0;
      tick(1);
      check({7'h00, srq}, 8'h00);
      tick(1);
      check(status_byte & 8'h20, 8'h20);
      check({7'h00, srq}, 8'h01);
      ask(isr_pkg::ISR_CMD_ESR_QUERY, 8'h01);
      tick(1);
      check({6'h00, status_byte[5], srq}, 8'h00);
      ask(isr_pkg::ISR_CMD_ESR_QUERY, 8'h00);
   endtask
   task automatic t_opcq();
      @(posedge ref_clk);
      op_busy <= 1'b1;
      wr(isr_pkg::ISR_CMD_OP_DONE_QUERY, 8'h00);
      tick(3);
      check(status_byte & 8'h10, 8'h00);
      @(posedge ref_clk);
      op_busy <= 1'b0;
      tick(1);
      check(status_byte & 8'h10, 8'h00);
      tick(1);
      check(status_byte & 8'h10, 8'h10);
      ask(isr_pkg::ISR_CMD_OUT_READ, 8'h31);
      tick(1);
      check(status_byte & 8'h10, 8'h00);
   endtask
   task automatic t_cls();
      wr(isr_pkg::ISR_CMD_ESE_WRITE, 8'h80);
      @(posedge ref_clk);
      std_event <= 8'h80;
      err_push <= 1'b1;
      err_code <= 8'h5a;
      @(posedge ref_clk);
      std_event <= 8'h00;
      err_push <= 1'b0;
      err_code <= 8'ha5;
      tick(3);
      check(status_byte & 8'h24, 8'h24);
      check({7'h00, srq}, 8'h01);
      wr(isr_pkg::ISR_CMD_CLS, 8'h00);
      tick(2);
      check(status_byte & 8'h24, 8'h00);
      check({7'h00, srq}, 8'h00);
      ask(isr_pkg::ISR_CMD_ERR_QUERY, 8'h00);
      ask(isr_pkg::ISR_CMD_ESR_QUERY, 8'h00);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // all scenarios need under a hundred cycles; ceiling leaves ample margin
   initial begin
      cycles = 0;
      forever begin
         @(posedge ref_clk);
         cycles++;
         if (cycles >= 3000) begin
            mismatches++;
            stop_test();
         end
      end
   end
   initial begin
      rst_b = 1'b0;
      op_busy = 1'b0;
      err_push = 1'b0;
      err_code = 8'h00;
      std_event = 8'h00;
      mismatches = 0;
      samples_checked = 0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      tick(1);
      t_reset();
      t_error();
      t_done();
      t_opcq();
      t_cls();
      stop_test();
   end
endmodule
